// ===== core/bcrd_top.sv
// Bus cycle direction, DRAM strobe and ready termination logic.
// Assumes one 100 MHz clock; all pins arrive synchronous to it.
`timescale 1ns/100ps
`include "bcrd_cfg.svh"

module bcrd_top
   import bcrd_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    resetn_i,
   // Cycle request from the core
   input  wire logic                    cyc_req_i,
   input  wire bcrd_req_s               req_i,
   output logic                         cyc_busy_o,
   output logic                         cyc_done_o,
   // Read data to the core
   input  wire logic [`BCRD_DATA_W-1:0] data_i,
   output logic [`BCRD_DATA_W-1:0]      rd_data_o,
   output logic                         rd_valid_o,
   // Configuration
   input  wire logic                    dram_en_i,
   input  wire bcrd_ws_cfg_s            ws_cfg_i,
   // Bus ownership
   input  wire logic                    bus_granted_i,
   // Direction pin
   input  wire logic                    write_direction_strobe_i,
   output logic                         write_direction_strobe_o,
   output logic                         write_direction_strobe_oe_o,
   // DRAM strobes
   output logic                         dram_write_enable_0_n_o,
   output logic                         dram_output_enable_n_o,
   // Ready
   input  wire logic                    ready_i,
   output logic                         ready_echo_out_o
);

   bcrd_state_e             state;
   bcrd_state_e             next_state;
   bcrd_req_s               cur_req;
   bcrd_req_s               next_req;
   logic                    start;
   logic                    cyc_end;
   logic                    int_ready;
   logic                    ready_any;
   logic                    next_dir;
   logic                    next_dir_oe;
   logic                    next_we_n;
   logic                    next_oe_n;
   logic                    next_done;
   logic                    next_rd_valid;
   logic [`BCRD_DATA_W-1:0] next_rd_data;

   // ----------------------------------------
   // Internal wait-state generator
   // ----------------------------------------
   bcrd_waitgen u_waitgen (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .start_i  (start),
      .end_i    (cyc_end),
      // Request as taken this edge; the held copy is one edge late
      .req_i    (next_req),
      .cfg_i    (ws_cfg_i),
      .ready_o  (int_ready)
   );

   // ----------------------------------------
   // Cycle sequencing
   // ----------------------------------------
   always_comb begin
      ready_any  = ready_i || int_ready;
      start      = (state == BCRD_IDLE) && cyc_req_i && !bus_granted_i;
      cyc_end    = (state == BCRD_BUSY) && ready_any;
      next_state = state;
      next_req   = cur_req;
      unique case (state)
         BCRD_IDLE: begin
            if (start) begin
               next_state = BCRD_BUSY;
               next_req   = req_i;
            end
         end
         BCRD_BUSY: begin
            // Back to idle; the next request is taken one edge later
            if (ready_any) begin
               next_state = BCRD_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Pin and data next values
   // ----------------------------------------
   always_comb begin
      next_dir = `BCRD_DIR_IDLE;
      if (bus_granted_i) begin
         // Master owns the pin; report the level it drives
         next_dir = write_direction_strobe_i;
      end else if (start) begin
         next_dir = req_i.write ? `BCRD_DIR_WRITE : `BCRD_DIR_IDLE;
      end else if ((state == BCRD_BUSY) && !ready_any) begin
         next_dir = cur_req.write ? `BCRD_DIR_WRITE : `BCRD_DIR_IDLE;
      end
      // Release the pin while an external master owns the bus
      next_dir_oe = !bus_granted_i;
      next_we_n   = `BCRD_STROBE_OFF;
      next_oe_n   = `BCRD_STROBE_OFF;
      if (dram_en_i && next_dir_oe && (next_state == BCRD_BUSY)) begin
         // Strobes follow the direction level, not the raw request
         next_we_n = (next_dir == `BCRD_DIR_WRITE) ? `BCRD_STROBE_ON : `BCRD_STROBE_OFF;
         next_oe_n = (next_dir == `BCRD_DIR_WRITE) ? `BCRD_STROBE_OFF : `BCRD_STROBE_ON;
      end
      next_done     = cyc_end;
      next_rd_valid = cyc_end && !cur_req.write;
      next_rd_data  = rd_data_o;
      if (cyc_end && !cur_req.write) begin
         next_rd_data = data_i;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state                       <= BCRD_IDLE;
         cur_req                     <= '0;
         cyc_busy_o                  <= 1'b0;
         cyc_done_o                  <= 1'b0;
         rd_data_o                   <= '0;
         rd_valid_o                  <= 1'b0;
         write_direction_strobe_o    <= `BCRD_DIR_IDLE;
         write_direction_strobe_oe_o <= 1'b0;
         dram_write_enable_0_n_o     <= `BCRD_STROBE_OFF;
         dram_output_enable_n_o      <= `BCRD_STROBE_OFF;
      end else begin
         state                       <= next_state;
         cur_req                     <= next_req;
         cyc_busy_o                  <= (next_state == BCRD_BUSY);
         cyc_done_o                  <= next_done;
         rd_data_o                   <= next_rd_data;
         rd_valid_o                  <= next_rd_valid;
         write_direction_strobe_o    <= next_dir;
         write_direction_strobe_oe_o <= next_dir_oe;
         dram_write_enable_0_n_o     <= next_we_n;
         dram_output_enable_n_o      <= next_oe_n;
      end
   end

   // ----------------------------------------
   // Ready echo
   // ----------------------------------------
   // The external term bypasses the flops so outside ready is seen the same cycle;
   // the internal term is already registered in the wait-state generator.
   always_comb begin
      ready_echo_out_o = int_ready || ((state == BCRD_BUSY) && ready_i);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   write_dir_low_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      start && req_i.write |=> !write_direction_strobe_o && cyc_busy_o)
      else $error("direction not low at start of write cycle");

   idle_dir_high_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      cyc_end |=> write_direction_strobe_o)
      else $error("direction not high after cycle end");

   grant_release_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      bus_granted_i |=> !write_direction_strobe_oe_o && !start)
      else $error("direction pin driven during bus grant");

   grant_dir_follow_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      bus_granted_i |=> write_direction_strobe_o == $past(write_direction_strobe_i))
      else $error("direction output does not follow master during grant");

   dram_strobe_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !dram_write_enable_0_n_o |-> dram_output_enable_n_o && !write_direction_strobe_o
      && write_direction_strobe_oe_o)
      else $error("DRAM write enable not tied to write direction");

   dram_off_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !dram_en_i |=> dram_write_enable_0_n_o && dram_output_enable_n_o)
      else $error("DRAM strobe active with controller disabled");

   read_capture_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      cyc_end && !cur_req.write |=> rd_valid_o && rd_data_o == $past(data_i))
      else $error("read data not captured at edge after ready");

   first_ready_ends_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      state == BCRD_BUSY && ready_i |=> state == BCRD_IDLE && cyc_done_o)
      else $error("cycle did not end on first ready sample");

   echo_external_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      state == BCRD_BUSY && ready_i |-> ready_echo_out_o)
      else $error("external ready not echoed in same cycle");

   echo_internal_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      int_ready |-> ready_echo_out_o && state == BCRD_BUSY)
      else $error("internal ready not echoed");

endmodule

// ===== core/bcrd_cfg.svh
// Constants for the bus cycle direction and ready block.
// Included by the package and the design modules; definitions only.
`ifndef BCRD_CFG_SVH
`define BCRD_CFG_SVH

// ----------------------------------------
// Bus widths and address decode for wait-state regions
// ----------------------------------------
`define BCRD_ADDR_W      32
`define BCRD_DATA_W      32
`define BCRD_REGION_HI   31
`define BCRD_REGION_LO   30
`define BCRD_REGIONS     4

// ----------------------------------------
// Wait-state count width and pin levels
// ----------------------------------------
`define BCRD_WAIT_W      4
`define BCRD_DIR_IDLE    1'b1
`define BCRD_DIR_WRITE   1'b0
`define BCRD_STROBE_OFF  1'b1
`define BCRD_STROBE_ON   1'b0

`endif

// ===== core/bcrd_pkg.sv
// Types shared by the bus cycle direction and ready block.
// Assumes bcrd_cfg.svh is on the include path.
`include "bcrd_cfg.svh"

package bcrd_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic {BCRD_IDLE, BCRD_BUSY} bcrd_state_e;

   typedef struct packed {
      logic                    write;
      logic [`BCRD_ADDR_W-1:0] addr;
   } bcrd_req_s;

   typedef struct packed {
      logic [`BCRD_REGIONS-1:0]              enable;
      logic [`BCRD_REGIONS*`BCRD_WAIT_W-1:0] waits;
   } bcrd_ws_cfg_s;

   typedef logic [`BCRD_WAIT_W-1:0] bcrd_wait_t;

   // ----------------------------------------
   // Region decode
   // ----------------------------------------
   function automatic logic [1:0] bcrd_region(input logic [`BCRD_ADDR_W-1:0] addr);
      bcrd_region = addr[`BCRD_REGION_HI:`BCRD_REGION_LO];
   endfunction

   function automatic bcrd_wait_t bcrd_wait_of(input bcrd_ws_cfg_s cfg,
                                               input logic [1:0] region);
      bcrd_wait_of = cfg.waits[region*`BCRD_WAIT_W +: `BCRD_WAIT_W];
   endfunction

endpackage

// ===== core/bcrd_waitgen.sv
// Internal wait-state ready generator, one timer per bus cycle.
// Assumes start_i pulses on the edge a cycle opens and end_i on the edge it closes.
`timescale 1ns/100ps
`include "bcrd_cfg.svh"

module bcrd_waitgen
   import bcrd_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Cycle control
   input  wire logic         start_i,
   input  wire logic         end_i,
   input  wire bcrd_req_s    req_i,
   input  wire bcrd_ws_cfg_s cfg_i,
   // Internal ready, one cycle, registered
   output logic              ready_o
);

   bcrd_wait_t cnt;
   bcrd_wait_t next_cnt;
   logic       armed;
   logic       next_armed;
   logic       next_ready;
   logic [1:0] region;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      region     = bcrd_region(req_i.addr);
      next_cnt   = cnt;
      next_armed = armed;
      next_ready = 1'b0;
      if (start_i) begin
         // Region picks the wait count; a disabled region leaves ready to outside
         next_cnt   = bcrd_wait_of(cfg_i, region);
         next_armed = cfg_i.enable[region] && (next_cnt != '0);
         next_ready = cfg_i.enable[region] && (next_cnt == '0);
      end else if (end_i) begin
         // Early external end disarms the timer
         next_armed = 1'b0;
      end else if (armed) begin
         next_cnt = cnt - bcrd_wait_t'(1);
         if (cnt == bcrd_wait_t'(1)) begin
            next_ready = 1'b1;
            next_armed = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt     <= '0;
         armed   <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         armed   <= next_armed;
         ready_o <= next_ready;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   zero_wait_ready_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      start_i && cfg_i.enable[region] && bcrd_wait_of(cfg_i, region) == '0
      |=> ready_o)
      else $error("zero wait region did not raise ready");

   one_wait_ready_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      start_i && cfg_i.enable[region] && bcrd_wait_of(cfg_i, region) == bcrd_wait_t'(1)
      ##1 !end_i |=> ready_o)
      else $error("one wait region did not raise ready after one wait");

   disabled_silent_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      start_i && !cfg_i.enable[region] |=> !ready_o [*2])
      else $error("disabled region produced internal ready");

   early_end_quiet_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      end_i && !start_i |=> !ready_o)
      else $error("internal ready after early external end");

endmodule

// ===== sim/bcrd_mem_model.sv
// External memory model: drives the data bus and an external ready.
// Assumes inputs from the bench settle before each falling clock edge.
`timescale 1ns/100ps

module bcrd_mem_model (
   // Clock
   input  wire logic        clk_i,
   // Observed cycle and test controls
   input  wire logic        busy_i,
   input  wire logic        ext_en_i,
   input  wire logic [7:0]  delay_i,
   // Memory side
   output logic             ready_o,
   output logic [31:0]      data_o
);
   logic [7:0] count;

   initial begin
      ready_o = 1'b0;
      data_o  = 32'h5a5a_0f0f;
      count   = 8'h00;
   end

   // ----------------------------------------
   // Data and ready
   // ----------------------------------------
   always @(negedge clk_i) begin
      // Data never stands still, so a stale capture cannot pass by luck
      data_o <= data_o + 32'h9e37_79b9;
      if (busy_i) begin
         count   <= count + 8'h01;
         ready_o <= ext_en_i && (count + 8'h01 == delay_i);
      end else begin
         count   <= 8'h00;
         ready_o <= 1'b0;
      end
   end
endmodule

// ===== sim/bcrd_top_tb_top.sv
// Self-checking bench for the direction, DRAM strobe and ready block.
// Assumes the design package and bcrd_cfg.svh are compiled first.
`timescale 1ns/100ps
`include "bcrd_cfg.svh"

module bcrd_top_tb_top
   import bcrd_pkg::*;
   ;
   logic                    clk_i = 1'b0;
   logic                    resetn_i = 1'b0;
   logic                    cyc_req_i = 1'b0;
   bcrd_req_s               req_i = '0;
   logic                    cyc_busy_o;
   logic                    cyc_done_o;
   logic [`BCRD_DATA_W-1:0] data_i;
   logic [`BCRD_DATA_W-1:0] rd_data_o;
   logic                    rd_valid_o;
   logic                    dram_en_i = 1'b1;
   bcrd_ws_cfg_s            ws_cfg_i = '{enable: 4'b1011, waits: 16'h9030};
   logic                    bus_granted_i = 1'b0;
   logic                    wdir_pin = 1'b1;
   logic                    write_direction_strobe_o;
   logic                    write_direction_strobe_oe_o;
   logic                    dram_write_enable_0_n_o;
   logic                    dram_output_enable_n_o;
   logic                    ready_i;
   logic                    ready_echo_out_o;
   logic                    ext_en = 1'b0;
   logic [7:0]              ext_delay = 8'h00;
   int                      err_total = 0;
   int                      check_count = 0;

   always #5 clk_i = ~clk_i;

   bcrd_top i_bcrd_top (
      .clk_i                       (clk_i),
      .resetn_i                    (resetn_i),
      .cyc_req_i                   (cyc_req_i),
      .req_i                       (req_i),
      .cyc_busy_o                  (cyc_busy_o),
      .cyc_done_o                  (cyc_done_o),
      .data_i                      (data_i),
      .rd_data_o                   (rd_data_o),
      .rd_valid_o                  (rd_valid_o),
      .dram_en_i                   (dram_en_i),
      .ws_cfg_i                    (ws_cfg_i),
      .bus_granted_i               (bus_granted_i),
      .write_direction_strobe_i    (wdir_pin),
      .write_direction_strobe_o    (write_direction_strobe_o),
      .write_direction_strobe_oe_o (write_direction_strobe_oe_o),
      .dram_write_enable_0_n_o     (dram_write_enable_0_n_o),
      .dram_output_enable_n_o      (dram_output_enable_n_o),
      .ready_i                     (ready_i),
      .ready_echo_out_o            (ready_echo_out_o)
   );

   bcrd_mem_model i_bcrd_mem_model (
      .clk_i    (clk_i),
      .busy_i   (cyc_busy_o),
      .ext_en_i (ext_en),
      .delay_i  (ext_delay),
      .ready_o  (ready_i),
      .data_o   (data_i)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One cycle from request to done; iwait < 0 means no internal ready
   task automatic bus_cycle(input logic w, input logic [31:0] a, input int iwait,
                            input int exp_n);
      int          n;
      logic [31:0] exp_data;
      n = 0;
      exp_data = '0;
      @(negedge clk_i);
      cyc_req_i = 1'b1;
      req_i = '{write: w, addr: a};
      @(negedge clk_i);
      cyc_req_i = 1'b0;
      #1;
      while (cyc_busy_o === 1'b1 && n < 50) begin
         n++;
         check(write_direction_strobe_o, !w);
         check(dram_write_enable_0_n_o, !(dram_en_i && w));
         check(dram_output_enable_n_o, !(dram_en_i && !w));
         check(ready_echo_out_o, (n == iwait + 1) || ready_i);
         exp_data = data_i;
         @(negedge clk_i);
         #1;
      end
      if (n >= 50) begin
         err_total++;
         conclude();
      end else begin
         check(32'(n), 32'(exp_n));
         check(cyc_done_o, 1'b1);
         check(write_direction_strobe_o, 1'b1);
         check(rd_valid_o, !w);
         if (!w) check(rd_data_o, exp_data);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      repeat (2) @(negedge clk_i);
      check(write_direction_strobe_o, 1'b1);
      check(dram_write_enable_0_n_o, 1'b1);
      check(ready_echo_out_o, 1'b0);
      resetn_i = 1'b1;
      repeat (2) @(negedge clk_i);
      check(write_direction_strobe_oe_o, 1'b1);
   endtask

   task automatic t_read_internal();
      bus_cycle(1'b0, 32'h0000_0010, 0, 1);
      bus_cycle(1'b0, 32'h4000_0020, 3, 4);
      // One wait state in region zero, then back to zero waits
      @(negedge clk_i);
      ws_cfg_i.waits[3:0] = 4'h1;
      bus_cycle(1'b0, 32'h0000_0030, 1, 2);
      @(negedge clk_i);
      ws_cfg_i.waits[3:0] = 4'h0;
   endtask

   task automatic t_write_external();
      ext_en = 1'b1;
      ext_delay = 8'h04;
      bus_cycle(1'b1, 32'h8000_0004, -1, 4);
   endtask

   task automatic t_early_external();
      ext_delay = 8'h02;
      bus_cycle(1'b1, 32'hc000_0008, 9, 2);
      bus_cycle(1'b0, 32'hc000_000c, 9, 2);
      ext_en = 1'b0;
   endtask

   task automatic t_no_dram();
      @(negedge clk_i);
      dram_en_i = 1'b0;
      bus_cycle(1'b0, 32'h0000_0000, 0, 1);
      bus_cycle(1'b1, 32'h4000_0000, 3, 4);
      @(negedge clk_i);
      dram_en_i = 1'b1;
   endtask

   task automatic t_grant();
      @(negedge clk_i);
      bus_granted_i = 1'b1;
      cyc_req_i = 1'b1;
      wdir_pin = 1'b0;
      repeat (3) @(negedge clk_i);
      check(write_direction_strobe_oe_o, 1'b0);
      check(cyc_busy_o, 1'b0);
      check(dram_write_enable_0_n_o, 1'b1);
      check(write_direction_strobe_o, 1'b0);
      bus_granted_i = 1'b0;
      cyc_req_i = 1'b0;
      wdir_pin = 1'b1;
      repeat (2) @(negedge clk_i);
      check(write_direction_strobe_oe_o, 1'b1);
      check(write_direction_strobe_o, 1'b1);
   endtask

   initial begin
      t_reset();
      t_read_internal();
      t_write_external();
      t_early_external();
      t_no_dram();
      t_grant();
      conclude();
   end
endmodule
